// file: hw/fdcrs_top.sv
// Command outcome reporting: result status bytes, drive status, invalid commands
// Behaviour
// - An undefined command byte ends at once and raises no interrupt.
// - After rejection, direction and request bits of main status both read high.
// - The single result byte of a rejected command is 80H.
// - Without sense-interrupt after seek or recalibrate, the next command is undefined.
// - Drive status query is accepted any time and returns drive status byte; the code rejects it with 80H while a sense-interrupt is due.
// - Termination code 00 means normal end, 01 started but failed.
// - Code 10 means invalid never started, 11 means ready changed during execution.
// - Seek completion sets the positioning done flag, bit 5.
// - Drive fault or 77 steps without track zero sets equipment check.
// - Read or write to a not-ready drive sets the not-ready flag.
// - Read or write to side one of a single sided drive sets not-ready.
// - Bit 2 holds the head side selected when the interrupt is raised.
// - Bits 1 and 0 hold the selected unit when the interrupt is raised.
// - Bit 7 of status one marks access beyond the last sector.
// - Bit 6 of status one always reads zero.
// - Bit 5 of status one marks a checksum error in ID or data field.
// - Sense-interrupt clears the pending interrupt and reports its cause.
//
// Local design decisions: the register offsets and the APB register port.
`default_nettype none
module fdcrs_top
   import fdcrs_pkg::*;
#(
   parameter int RECAL_STEPS = FDCRS_RECAL_STEPS
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Drive lines
   input  wire fdcrs_drv_t  drv,
   input  wire logic        step_pulse,
   input  wire logic        pos_done,
   // Data engine
   input  wire logic        exec_done,
   input  wire logic        exec_abnormal,
   input  wire logic        end_of_cyl,
   input  wire logic        crc_err,
   output logic             exec_go,
   output logic             pos_go,
   output logic      [1:0]  sel_unit,
   output logic             sel_head,
   // Interrupt
   output logic             irq
);

   // ************************************************************
   // State
   // ************************************************************
   fdcrs_phase_t phase;
   fdcrs_st0_t   st0;
   fdcrs_st0_t   cause;
   logic [7:0]   st1;
   logic [7:0]   res [0:1];
   logic         res_idx;
   logic         res_last;
   logic         sense_due;
   logic         pos_busy;
   logic         pos_recal;
   logic [6:0]   step_cnt;
   logic [2:0]   isr;
   logic [2:0]   imr;
   logic         rdy_q;
   logic         rdy_seen;

   // ************************************************************
   // Bus decode
   // ************************************************************
   logic       acc;
   logic       cmd_wr;
   logic       rd_res;
   logic [4:0] op;
   logic [1:0] wunit;
   logic       whead;
   logic       bad;
   logic       rdy_chg;
   logic [7:0] msr_val;
   logic [7:0] next_st1;

   // Writes and pops act only on the edge that completes the transfer
   assign acc      = psel && penable && pready;
   assign cmd_wr   = acc && pwrite && paddr == FDCRS_CMD && phase == PH_CMD;
   assign rd_res   = acc && !pwrite && paddr == FDCRS_RES && phase == PH_RES;
   assign op       = pwdata[4:0];
   assign wunit    = pwdata[9:8];
   assign whead    = pwdata[10];
   assign bad      = !fdcrs_defined(op) || (sense_due && op != OP_SENSE_INT);
   assign rdy_chg  = rdy_seen && rdy_q != drv.ready;
   assign next_st1 = st1 | {end_of_cyl, 1'b0, crc_err, 5'b0_0000};
   // Request stands except while a command executes; direction points out in result
   assign msr_val  = {phase != PH_EXEC, phase == PH_RES, 1'b0, phase != PH_CMD, 4'h0};

   // ************************************************************
   // Interrupt events
   // ************************************************************
   logic [2:0] ev_set;
   logic [2:0] ev_clr;
   logic [2:0] next_isr;
   logic       pos_fin;
   fdcrs_st0_t pos_st0;
   logic       rw_reject;

   assign rw_reject = cmd_wr && !bad && fdcrs_is_rw(op) && (!drv.ready || (whead && !drv.two_side));

   // Positioning end: track zero, seek done, step limit, or drive lost
   always_comb begin
      pos_fin = 1'b0;
      pos_st0 = {FDCRS_TERM_OK, 1'b1, drv.fault, 1'b0, sel_head, sel_unit};
      if (pos_busy) begin
         if (!drv.ready) begin
            pos_fin = 1'b1;
            pos_st0 = {FDCRS_TERM_ABN, 1'b1, drv.fault, 1'b1, sel_head, sel_unit};
         end else if (pos_recal && drv.track0) begin
            pos_fin = 1'b1;
         end else if (pos_recal && step_pulse && 32'(step_cnt) == RECAL_STEPS - 1) begin
            pos_fin = 1'b1;
            pos_st0 = {FDCRS_TERM_ABN, 1'b1, 1'b1, 1'b0, sel_head, sel_unit};
         end else if (!pos_recal && pos_done) begin
            pos_fin = 1'b1;
         end
      end
   end

   // An invalid command contributes to no event
   always_comb begin
      ev_set = FDCRS_EV_RST;
      ev_set[FDCRS_EV_RES] = rw_reject || (phase == PH_EXEC && (exec_done || rdy_chg));
      ev_set[FDCRS_EV_POS] = pos_fin;
      ev_set[FDCRS_EV_RDY] = rdy_chg && phase != PH_EXEC;
      ev_clr = FDCRS_EV_RST;
      if (acc && pwrite && paddr == FDCRS_ISR) begin
         ev_clr = pwdata[2:0];
      end
      if (cmd_wr && !bad && op == OP_SENSE_INT) begin
         ev_clr[FDCRS_EV_POS] = 1'b1;
         ev_clr[FDCRS_EV_RDY] = 1'b1;
      end
      next_isr = (isr & ~ev_clr) | ev_set;  // A new event beats its clear
   end

   // Sticky status, mask and the interrupt line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isr <= FDCRS_EV_RST;
         imr <= FDCRS_EV_RST;
         irq <= 1'b0;
      end else begin
         isr <= next_isr;
         irq <= |(next_isr & imr);
         if (acc && pwrite && paddr == FDCRS_IMR) begin
            imr <= pwdata[2:0];
         end
      end
   end

   // ************************************************************
   // APB answer: one wait state, then data and error from flops
   // ************************************************************
   logic [31:0] rd_val;
   logic        rd_ok;

   always_comb begin
      rd_val = '0;
      rd_ok  = 1'b1;
      case (paddr)
         FDCRS_CMD: rd_val = '0;
         FDCRS_MSR: rd_val = 32'(msr_val);
         FDCRS_RES: rd_val = 32'(res[res_idx]);
         FDCRS_ST0: rd_val = 32'(st0);
         FDCRS_ST1: rd_val = 32'(st1);
         FDCRS_ISR: rd_val = 32'(isr);
         FDCRS_IMR: rd_val = 32'(imr);
         default:   rd_ok  = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rd_ok;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   // ************************************************************
   // Ready line watch
   // ************************************************************
   // First sample only arms the detector, so release from reset is no change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_q    <= 1'b0;
         rdy_seen <= 1'b0;
      end else begin
         rdy_q    <= drv.ready;
         rdy_seen <= 1'b1;
      end
   end

   // ************************************************************
   // Background positioning and the pending cause
   // ************************************************************
   // One positioning runs at a time; a second seek while busy is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_busy  <= 1'b0;
         pos_recal <= 1'b0;
         pos_go    <= 1'b0;
         step_cnt  <= '0;
         sense_due <= 1'b0;
         cause     <= FDCRS_BYTE_RST;
      end else begin
         pos_go <= 1'b0;
         if (cmd_wr && !bad && op == OP_SENSE_INT) begin
            sense_due <= 1'b0;
         end
         if (cmd_wr && !bad && (op == OP_SEEK || op == OP_RECAL) && !pos_busy) begin
            pos_busy  <= 1'b1;
            pos_recal <= op == OP_RECAL;
            pos_go    <= 1'b1;
            step_cnt  <= '0;
         end else if (pos_fin) begin
            pos_busy  <= 1'b0;
            cause     <= pos_st0;
            sense_due <= 1'b1;
         end else if (pos_busy && step_pulse) begin
            step_cnt <= step_cnt + 7'd1;
         end
         if (rdy_chg && phase != PH_EXEC && !pos_fin) begin
            cause     <= {FDCRS_TERM_RDY, 1'b0, drv.fault, !drv.ready, sel_head, sel_unit};
            sense_due <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Command, execution and result phases
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase    <= PH_CMD;
         st0      <= FDCRS_BYTE_RST;
         st1      <= FDCRS_BYTE_RST;
         res[0]   <= FDCRS_BYTE_RST;
         res[1]   <= FDCRS_BYTE_RST;
         res_idx  <= 1'b0;
         res_last <= 1'b0;
         exec_go  <= 1'b0;
         sel_unit <= 2'h0;
         sel_head <= 1'b0;
      end else begin
         exec_go <= 1'b0;
         case (phase)
            PH_CMD: begin
               if (cmd_wr) begin
                  res_idx  <= 1'b0;
                  res_last <= 1'b0;
                  if (bad) begin
                     res[0] <= FDCRS_ST0_INVALID;
                     phase  <= PH_RES;
                  end else if (op == OP_SENSE_DRV) begin
                     res[0] <= {drv.fault, drv.wprot, drv.ready, drv.track0,
                                drv.two_side, whead, wunit};
                     phase  <= PH_RES;
                  end else if (op == OP_SENSE_INT) begin
                     res[0] <= cause;
                     st0    <= cause;
                     phase  <= PH_RES;
                  end else if (fdcrs_is_rw(op)) begin
                     sel_unit <= wunit;
                     sel_head <= whead;
                     st1      <= FDCRS_BYTE_RST;
                     if (rw_reject) begin
                        st0      <= {FDCRS_TERM_ABN, 1'b0, drv.fault, 1'b1, whead, wunit};
                        res[0]   <= {FDCRS_TERM_ABN, 1'b0, drv.fault, 1'b1, whead, wunit};
                        res[1]   <= FDCRS_BYTE_RST;
                        res_last <= 1'b1;
                        phase    <= PH_RES;
                     end else begin
                        exec_go <= 1'b1;
                        phase   <= PH_EXEC;
                     end
                  end else if (op == OP_SEEK || op == OP_RECAL) begin
                     sel_unit <= wunit;
                     sel_head <= whead;
                  end
               end
            end
            PH_EXEC: begin
               st1 <= next_st1;
               if (rdy_chg || exec_done) begin
                  st0.term    <= rdy_chg ? FDCRS_TERM_RDY :
                                 (exec_abnormal ? FDCRS_TERM_ABN : FDCRS_TERM_OK);
                  st0.fault   <= drv.fault;
                  st0.not_rdy <= !drv.ready;
                  st0.head    <= sel_head;
                  {st0.unit_hi, st0.unit_lo} <= sel_unit;
                  st0.seek_done <= 1'b0;
                  res[0] <= {rdy_chg ? FDCRS_TERM_RDY : (exec_abnormal ? FDCRS_TERM_ABN : FDCRS_TERM_OK),
                             1'b0, drv.fault, !drv.ready, sel_head, sel_unit};
                  res[1]   <= next_st1;
                  res_last <= 1'b1;
                  phase    <= PH_RES;
               end
            end
            PH_RES: begin
               if (rd_res) begin
                  if (res_idx == res_last) begin
                     phase <= PH_CMD;
                  end else begin
                     res_idx <= 1'b1;
                  end
               end
            end
            default: phase <= PH_CMD;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_inv_res;
      cmd_wr && bad |=> phase == PH_RES && res[0] == 8'h80 && !res_last;
   endproperty
   a_inv_res: assert property (p_inv_res) else $error("rejected command result not 80H");

   property p_inv_msr;
      cmd_wr && bad |=> msr_val[FDCRS_MSR_RQM] && msr_val[FDCRS_MSR_DIO];
   endproperty
   a_inv_msr: assert property (p_inv_msr) else $error("request and direction not high");

   property p_inv_noirq;
      cmd_wr && bad && !pos_fin && !rdy_chg |=> isr == $past(isr);
   endproperty
   a_inv_noirq: assert property (p_inv_noirq) else $error("rejected command raised event");

   property p_sense_due;
      cmd_wr && sense_due && op != OP_SENSE_INT |=> res[0] == 8'h80 ##1 phase != PH_EXEC;
   endproperty
   a_sense_due: assert property (p_sense_due) else $error("missing sense not rejected");

   property p_drv;
      cmd_wr && !bad && op == OP_SENSE_DRV |=>
         res[0] == {$past(drv.fault), $past(drv.wprot), $past(drv.ready), $past(drv.track0),
                    $past(drv.two_side), $past(whead), $past(wunit)};
   endproperty
   a_drv: assert property (p_drv) else $error("drive status byte wrong");

   property p_recal_ec;
      pos_busy && pos_recal && drv.ready && !drv.track0 && step_pulse && 32'(step_cnt) == RECAL_STEPS - 1
         |=> cause.fault && cause.seek_done && cause.term == 2'h1 && sense_due && !pos_busy;
   endproperty
   a_recal_ec: assert property (p_recal_ec) else $error("step limit not flagged");

   property p_one_side;
      cmd_wr && !bad && fdcrs_is_rw(op) && drv.ready && whead && !drv.two_side
         |=> st0.not_rdy && st0.term == 2'h1 && st0.head;
   endproperty
   a_one_side: assert property (p_one_side) else $error("single side access not refused");

   property p_rdy_abort;
      phase == PH_EXEC && rdy_chg |=> st0.term == 2'h3 && phase == PH_RES && isr[FDCRS_EV_RES];
   endproperty
   a_rdy_abort: assert property (p_rdy_abort) else $error("ready change not reported");

   property p_st1_zero;
      phase == PH_RES && res_last |-> res[1][6] == 1'b0 && st1[6] == 1'b0;
   endproperty
   a_st1_zero: assert property (p_st1_zero) else $error("unused status one bit set");

   property p_sense_clr;
      cmd_wr && !bad && op == OP_SENSE_INT && !pos_fin && !rdy_chg
         |=> !sense_due && !isr[FDCRS_EV_POS] && res[0] == $past(cause);
   endproperty
   a_sense_clr: assert property (p_sense_clr) else $error("sense did not clear interrupt");

   property p_res_back;
      rd_res && res_idx == res_last |=> phase == PH_CMD;
   endproperty
   a_res_back: assert property (p_res_back) else $error("no return to command phase");

endmodule : fdcrs_top
`default_nettype wire

// file: hw/fdcrs_pkg.sv
// Constants, types and command decoding for the result status reporting block
`default_nettype none
package fdcrs_pkg;
   // ************************************************************
   // Register map (byte addresses on the APB bus)
   // ************************************************************
   localparam logic [7:0] FDCRS_CMD = 8'h00;  // Command word, write
   localparam logic [7:0] FDCRS_MSR = 8'h04;  // Main status, read
   localparam logic [7:0] FDCRS_RES = 8'h08;  // Result byte, read pops
   localparam logic [7:0] FDCRS_ST0 = 8'h0C;  // result_status_zero
   localparam logic [7:0] FDCRS_ST1 = 8'h10;  // result_status_one
   localparam logic [7:0] FDCRS_ISR = 8'h14;  // Sticky events, write one to clear
   localparam logic [7:0] FDCRS_IMR = 8'h18;  // Event mask

   // ************************************************************
   // Field positions, values and counts
   // ************************************************************
   localparam int         FDCRS_MSR_RQM     = 7;      // master_request_bit
   localparam int         FDCRS_MSR_DIO     = 6;      // transfer_direction_bit
   localparam int         FDCRS_MSR_BUSY    = 4;
   localparam int         FDCRS_ST1_EOC     = 7;
   localparam int         FDCRS_ST1_CRC     = 5;      // crc_fault_flag
   localparam int         FDCRS_EV_RES      = 0;
   localparam int         FDCRS_EV_POS      = 1;
   localparam int         FDCRS_EV_RDY      = 2;
   localparam logic [1:0] FDCRS_TERM_OK     = 2'h0;
   localparam logic [1:0] FDCRS_TERM_ABN    = 2'h1;
   localparam logic [1:0] FDCRS_TERM_INV    = 2'h2;
   localparam logic [1:0] FDCRS_TERM_RDY    = 2'h3;
   localparam logic [7:0] FDCRS_ST0_INVALID = 8'h80;
   localparam logic [7:0] FDCRS_BYTE_RST    = 8'h00;
   localparam logic [2:0] FDCRS_EV_RST      = 3'h0;
   localparam int         FDCRS_RECAL_STEPS = 77;

   // ************************************************************
   // Opcodes (low five bits of the command byte)
   // ************************************************************
   localparam logic [4:0] OP_SPECIFY   = 5'h03;
   localparam logic [4:0] OP_SENSE_DRV = 5'h04;
   localparam logic [4:0] OP_RECAL     = 5'h07;
   localparam logic [4:0] OP_SENSE_INT = 5'h08;
   localparam logic [4:0] OP_SEEK      = 5'h0F;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic [1:0] term;        // termination_code
      logic       seek_done;   // positioning_done_flag
      logic       fault;       // drive_fault_flag
      logic       not_rdy;     // drive_not_ready_flag
      logic       head;        // head_side_flag
      logic       unit_hi;     // unit_sel_hi
      logic       unit_lo;     // unit_sel_lo
   } fdcrs_st0_t;

   typedef struct packed {
      logic fault;
      logic wprot;
      logic ready;
      logic track0;
      logic two_side;
   } fdcrs_drv_t;

   typedef enum {PH_CMD, PH_EXEC, PH_RES} fdcrs_phase_t;

   // Data transfer commands: reads, writes, format, scans
   function automatic logic fdcrs_is_rw(input logic [4:0] op);
      case (op)
         5'h02, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h11, 5'h19, 5'h1D: fdcrs_is_rw = 1'b1;
         default: fdcrs_is_rw = 1'b0;
      endcase
   endfunction : fdcrs_is_rw

   function automatic logic fdcrs_defined(input logic [4:0] op);
      fdcrs_defined = fdcrs_is_rw(op) || op == OP_SPECIFY || op == OP_SENSE_DRV ||
                      op == OP_RECAL || op == OP_SENSE_INT || op == OP_SEEK;
   endfunction : fdcrs_defined
endpackage : fdcrs_pkg
`default_nettype wire

// file: tb/fdcrs_drive_model.sv
// Drive and data engine model that answers the controller's start pulses
`default_nettype none
module fdcrs_drive_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Start pulses and scenario choice
   input  wire logic exec_go,
   input  wire logic pos_go,
   input  wire logic seek_ok,
   // Answers to the controller
   output logic      step_pulse,
   output logic      pos_done,
   output logic      exec_done,
   output logic      end_of_cyl,
   output logic      crc_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] ecnt;
   logic [4:0] pcnt;
   // Data engine: both faults land mid-transfer, then a normal end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ecnt <= 5'h00;
      else if (exec_go) ecnt <= 5'h06;
      else if (ecnt != 5'h00) ecnt <= ecnt - 5'h01;
   end
   assign end_of_cyl = (ecnt == 5'h04);
   assign crc_err    = (ecnt == 5'h03);
   assign exec_done  = (ecnt == 5'h01);
   // Positioning: target found, or ten steps that never reach track zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pcnt <= 5'h00;
      else if (pos_go) pcnt <= 5'h14;
      else if (pcnt != 5'h00) pcnt <= pcnt - 5'h01;
   end
   assign pos_done   = seek_ok && (pcnt == 5'h10);
   assign step_pulse = !seek_ok && pcnt[0];
endmodule : fdcrs_drive_model
`default_nettype wire

// file: tb/test_fdcrs_top.sv
// Self-checking bench for the result status reporting block
`default_nettype none
module test_fdcrs_top
   import fdcrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, seek_ok = 1'b1;
   logic [31:0] pwdata = 32'h0000_0000;
   fdcrs_drv_t  drv = 5'h0D;
   logic [31:0] prdata, rv;
   logic [1:0]  sel_unit;
   logic        pready, pslverr, exec_go, pos_go, irq, erv, sel_head;
   logic        exec_abn = 1'b0;
   logic        step_pulse, pos_done, exec_done, end_of_cyl, crc_err;
   int          fail_count = 0;
   int          check_count = 0;

   always #2 pclk = ~pclk;

   fdcrs_top #(.RECAL_STEPS(4)) fdcrs_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .drv, .step_pulse, .pos_done, .exec_done,
      .exec_abnormal(exec_abn), .end_of_cyl, .crc_err, .exec_go, .pos_go, .sel_unit, .sel_head, .irq);
   fdcrs_drive_model fdcrs_drive_model_i (.pclk, .presetn, .exec_go, .pos_go, .seek_ok,
      .step_pulse, .pos_done, .exec_done, .end_of_cyl, .crc_err);

   // ************************************************************
   // Bus and check tasks
   // ************************************************************
   // One APB transfer; the request stands until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) fail_count++;
   endtask : xfer
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk
   // Command word packs head, unit and opcode
   task automatic cmd(input logic [4:0] op, input logic [1:0] u, input logic h);
      xfer(1'b1, FDCRS_CMD, {21'h0, h, u, 3'h0, op});
   endtask : cmd
   task automatic res(input string nm, input logic [7:0] e);
      xfer(1'b0, FDCRS_RES, 32'h0000_0000);
      chk(nm, {24'h0, e}, rv);
   endtask : res
   // Poll the sticky events; bounded so a lost event cannot hang
   task automatic wait_ev(input int b);
      int n;
      n = 0;
      do begin
         xfer(1'b0, FDCRS_ISR, 32'h0000_0000);
         n++;
      end while (rv[b] !== 1'b1 && n < 30);
      chk("event", 32'h1, {31'h0, rv[b]});
   endtask : wait_ev
   // Irq is registered, so let two edges land first
   task automatic chk_irq(input string nm, input logic e);
      repeat (2) @(negedge pclk);
      chk(nm, {31'h0, e}, {31'h0, irq});
   endtask : chk_irq
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      #40000;
      fail_count++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, FDCRS_ISR, 32'h0000_0000);
      chk("isr reset", 32'h0, rv);
      xfer(1'b1, FDCRS_IMR, 32'h6);
      // Undefined opcode, expected to be rejected with 80H
      cmd(5'h00, 2'h0, 1'b0);
      xfer(1'b0, FDCRS_MSR, 32'h0000_0000);
      chk("msr result", 32'hC0, rv & 32'hC0);
      xfer(1'b0, FDCRS_ISR, 32'h0000_0000);
      chk("no event", 32'h0, rv);
      chk_irq("irq invalid", 1'b0);
      res("invalid st0", 8'h80);
      xfer(1'b0, FDCRS_MSR, 32'h0000_0000);
      chk("msr command", 32'h0, rv & 32'h40);
      $display("test invalid done");
      cmd(OP_SENSE_DRV, 2'h2, 1'b1);
      res("drive status", 8'h6E);
      $display("test drive status done");
      // Seek, then a command that skips the sense step
      cmd(OP_SEEK, 2'h1, 1'b0);
      wait_ev(FDCRS_EV_POS);
      chk_irq("irq seek", 1'b1);
      cmd(OP_SENSE_DRV, 2'h1, 1'b0);
      res("no sense", 8'h80);
      cmd(OP_SENSE_INT, 2'h0, 1'b0);
      res("seek st0", 8'h21);
      chk_irq("irq sensed", 1'b0);
      $display("test seek done");
      // Recalibrate that never sees track zero
      seek_ok <= 1'b0;
      cmd(OP_RECAL, 2'h0, 1'b0);
      wait_ev(FDCRS_EV_POS);
      cmd(OP_SENSE_INT, 2'h0, 1'b0);
      res("recal st0", 8'h70);
      $display("test recal done");
      // Data command with both faults, first masked then unmasked
      cmd(5'h06, 2'h2, 1'b1);
      wait_ev(FDCRS_EV_RES);
      chk_irq("irq masked", 1'b0);
      xfer(1'b1, FDCRS_IMR, 32'h7);
      chk_irq("irq unmasked", 1'b1);
      chk("unit", 32'h2, {30'h0, sel_unit});
      chk("head", 32'h1, {31'h0, sel_head});
      xfer(1'b0, FDCRS_ST1, 32'h0000_0000);
      chk("st1", 32'hA0, rv);
      res("data st0", 8'h06);
      res("data st1", 8'hA0);
      xfer(1'b1, FDCRS_ISR, 32'h1);
      chk_irq("irq cleared", 1'b0);
      $display("test data done");
      // Same command ending abnormally, then one cut short by a ready drop
      exec_abn <= 1'b1;
      cmd(5'h06, 2'h2, 1'b1);
      wait_ev(FDCRS_EV_RES);
      res("abnormal st0", 8'h46);
      res("abnormal st1", 8'hA0);
      xfer(1'b1, FDCRS_ISR, 32'h1);
      cmd(5'h06, 2'h2, 1'b1);
      drv <= 5'h09;
      wait_ev(FDCRS_EV_RES);
      res("ready abort st0", 8'hCE);
      res("ready abort st1", 8'h00);
      drv <= 5'h0D;
      wait_ev(FDCRS_EV_RDY);
      cmd(OP_SENSE_INT, 2'h0, 1'b0);
      res("ready back cause", 8'hC6);
      $display("test abnormal done");
      // Side one of a single sided drive, then a drive that is not ready
      drv <= 5'h0C;
      cmd(5'h05, 2'h0, 1'b1);
      res("one side st0", 8'h4C);
      xfer(1'b0, FDCRS_RES, 32'h0000_0000);
      drv <= 5'h09;
      wait_ev(FDCRS_EV_RDY);
      cmd(OP_SENSE_INT, 2'h0, 1'b0);
      xfer(1'b0, FDCRS_RES, 32'h0000_0000);
      chk("ready cause", 32'hC0, rv & 32'hE0);
      cmd(5'h05, 2'h3, 1'b0);
      res("not ready st0", 8'h4B);
      xfer(1'b0, FDCRS_RES, 32'h0000_0000);
      drv <= 5'h0D;
      wait_ev(FDCRS_EV_RDY);
      cmd(OP_SENSE_INT, 2'h0, 1'b0);
      xfer(1'b0, FDCRS_RES, 32'h0000_0000);
      xfer(1'b1, FDCRS_ISR, 32'h7);
      chk_irq("irq idle", 1'b0);
      $display("test not ready done");
      xfer(1'b0, 8'h1C, 32'h0000_0000);
      chk("unmapped", 32'h1, {31'h0, erv});
      $display("test unmapped done");
      close_out();
   end
endmodule : test_fdcrs_top
`default_nettype wire
